// file: verilog/pmm_memory_map.sv
// Purpose: Program counter and data memory address map of the core
// Assumes: Core fetch and data logic on sys_clk_i
// Notes:   Special registers live outside; their accesses are routed out
//          RAM is one 256-byte block shared by bank pairs
//          Reads answer one cycle after the request
`timescale 1ns/100ps
`include "pmm_consts.svh"
module pmm_memory_map
	import pmm_pkg::*;
#(
	parameter int PC_W   = `PMM_PC_W,
	parameter int PROG_AW = `PMM_PROG_AW
) (
	// Clock and reset
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_n_i,
	// Program counter control
	input  wire logic                    pc_advance_i,
	input  wire logic                    pc_load_i,
	input  wire logic [PC_W-1:0]         pc_target_i,
	input  wire logic                    int_take_i,
	output logic      [PC_W-1:0]         pc_o,
	output logic      [PROG_AW-1:0]      prog_addr_o,
	// Bank selection and pointer
	input  wire logic                    bank_select_high_i,
	input  wire logic                    bank_select_low_i,
	input  wire logic                    indirect_bank_i,
	input  wire logic [7:0]              indirect_pointer_i,
	// Data request
	input  wire pmm_data_req_t           data_req_i,
	output logic      [7:0]              data_rdata_o,
	output logic                         data_rvalid_o,
	// Special register side
	output logic                         sfr_sel_o,
	output logic      [`PMM_DATA_AW-1:0] sfr_addr_o,
	output logic                         sfr_write_o,
	output logic      [7:0]              sfr_wdata_o,
	input  wire logic [7:0]              sfr_rdata_i,
	// Decode status
	output logic      [1:0]              bank_o,
	output logic                         gpr_hit_o
);
	localparam int RAM_AW  = `PMM_GPR_AW;
	localparam int DATA_AW = `PMM_DATA_AW;
	localparam int OFF_AW  = `PMM_BANK_AW;

	// Low part of each bank belongs to the special registers
	function automatic logic is_special(input logic [OFF_AW-1:0] off);
		is_special = (off <= `PMM_SFR_TOP);
	endfunction

	// Mirrored special registers answer at the bank 0 location
	function automatic logic is_mirrored(input logic [OFF_AW-1:0] off);
		logic low_set;
		logic pair_set;
		low_set     = (off <= `PMM_MIRROR_LAST);
		pair_set    = (off == `PMM_MIRROR_PCH) || (off == `PMM_MIRROR_INT);
		is_mirrored = low_set || pair_set;
	endfunction

	// Offset of an address inside its bank
	function automatic logic [OFF_AW-1:0] offset_of(input logic [DATA_AW-1:0] a);
		offset_of = a[OFF_AW-1:0];
	endfunction

	// Bank bits sit above the in-bank offset
	function automatic logic [DATA_AW-1:0] direct_addr(input logic [1:0] bank, input logic [OFF_AW-1:0] off);
		direct_addr = {bank, off};
	endfunction

	// Indirect bank bit sits above the pointer
	function automatic logic [DATA_AW-1:0] indirect_addr(input logic hi, input logic [7:0] ptr);
		indirect_addr = {hi, ptr};
	endfunction

	// Offset zero is no register: it stands for the pointer
	function automatic logic is_pointer_loc(input logic [OFF_AW-1:0] off);
		is_pointer_loc = (off == `PMM_INDIRECT_LOC);
	endfunction

	// Fetch address drops the counter's top bit
	function automatic logic [PROG_AW-1:0] fetch_addr(input logic [PC_W-1:0] p);
		fetch_addr = p[PROG_AW-1:0];
	endfunction

	// Region and special register address of one data address
	function automatic pmm_decode_t decode(input logic [DATA_AW-1:0] a);
		pmm_decode_t       d;
		logic [OFF_AW-1:0] off;
		off         = offset_of(a);
		d.full_addr = a;
		d.sfr_addr  = a;
		d.region    = PMM_REG_GPR;
		if (is_special(off)) begin
			d.region = PMM_REG_SFR;
			if (is_mirrored(off)) begin
				d.sfr_addr = {2'b00, off};
			end
		end
		decode = d;
	endfunction

	// Program counter
	logic [PC_W-1:0] pc;
	logic [PC_W-1:0] next_pc;

	// Step wraps at the counter width
	wire logic [PC_W-1:0] pc_step   = PC_W'(pc + 1'b1);
	wire logic [PC_W-1:0] pc_linear = pc_advance_i ? pc_step : pc;
	wire logic [PC_W-1:0] pc_jump   = pc_load_i ? pc_target_i : pc_linear;

	// Interrupt beats load beats advance
	assign next_pc = int_take_i ? PC_W'(`PMM_INT_VEC) : pc_jump;

	// Asynchronous reset puts the counter on the reset vector
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc <= PC_W'(`PMM_RESET_VEC);
		end else begin
			pc <= next_pc;
		end
	end

	assign pc_o        = pc;
	// Upper counter bit ignored so high fetches fold into 4K
	wire logic [PROG_AW-1:0] fetch_a = fetch_addr(pc);
	assign prog_addr_o = fetch_a;

	// Data address formation
	wire logic [1:0]         bank_sel = {bank_select_high_i, bank_select_low_i};
	wire logic [OFF_AW-1:0]  req_off  = data_req_i.bank_addr;
	wire logic [DATA_AW-1:0] direct_a = direct_addr(bank_sel, req_off);
	wire logic [DATA_AW-1:0] ind_a    = indirect_addr(indirect_bank_i, indirect_pointer_i);
	wire logic               ptr_loc  = is_pointer_loc(req_off);
	wire logic               use_ind  = data_req_i.indirect || ptr_loc;
	wire logic [DATA_AW-1:0] eff_a    = use_ind ? ind_a : direct_a;
	wire pmm_decode_t        dec      = decode(eff_a);
	// Region flags of the effective address
	wire logic               is_gpr   = (dec.region == PMM_REG_GPR);
	wire logic               is_sfr   = (dec.region == PMM_REG_SFR);
	wire logic               rd_req   = data_req_i.valid && !data_req_i.write;
	wire logic               wr_req   = data_req_i.valid && data_req_i.write;
	wire logic               gpr_hit  = data_req_i.valid && is_gpr;
	wire logic               sfr_hit  = data_req_i.valid && is_sfr;
	wire logic               sfr_wr   = is_sfr && wr_req;
	// RAM indexed by the low address byte, so banks 0/2 and 1/3 alias
	wire logic [RAM_AW-1:0]  ram_a    = RAM_AW'(dec.full_addr);
	// RAM port, one access a cycle
	wire logic               ram_en   = gpr_hit;
	wire logic               ram_we   = data_req_i.write;
	wire logic [7:0]         ram_wd   = data_req_i.wdata;

	// Special register side
	assign sfr_sel_o   = sfr_hit;
	assign sfr_addr_o  = dec.sfr_addr;
	assign sfr_write_o = sfr_wr;
	assign sfr_wdata_o = data_req_i.wdata;

	// Decode status
	assign bank_o      = bank_sel;
	assign gpr_hit_o   = gpr_hit;

	logic [7:0] ram_rdata;

	pmm_gpr_ram #(
		.DEPTH (`PMM_GPR_DEPTH),
		.AW    (RAM_AW)
	) u_ram (
		.sys_clk_i (sys_clk_i),
		.en_i      (ram_en),
		.we_i      (ram_we),
		.addr_i    (ram_a),
		.wdata_i   (ram_wd),
		.rdata_o   (ram_rdata)
	);

	// Read return, one cycle after the request
	logic       rd_pend;
	logic       rd_gpr;
	logic [7:0] sfr_q;
	logic       next_rd_pend;
	logic       next_rd_gpr;

	// Writes never raise the valid pulse
	assign next_rd_pend = rd_req;
	// Steers the return mux to the RAM for the next cycle
	assign next_rd_gpr  = gpr_hit;

	// Reset clears the valid pulse so no stale read is seen
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_pend <= 1'b0;
			rd_gpr  <= 1'b0;
		end else begin
			rd_pend <= next_rd_pend;
			rd_gpr  <= next_rd_gpr;
		end
	end

	// Special register data captured in the request cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sfr_q <= 8'h00;
		end else begin
			sfr_q <= sfr_rdata_i;
		end
	end

	assign data_rvalid_o = rd_pend;
	assign data_rdata_o  = rd_gpr ? ram_rdata : sfr_q;
endmodule

// file: inc/pmm_consts.svh
// Purpose: Constants for the program and data memory map
// Assumes: 125 MHz core clock
// Notes:   Definitions only
`ifndef PMM_CONSTS_SVH
`define PMM_CONSTS_SVH
`define PMM_PC_W         13
`define PMM_PROG_AW      12
`define PMM_RESET_VEC    13'h0000
`define PMM_INT_VEC      13'h0004
`define PMM_BANK_AW      7
`define PMM_DATA_AW      9
`define PMM_SFR_TOP      7'h1f
`define PMM_SHARED_BASE  7'h70
`define PMM_INDIRECT_LOC 7'h00
`define PMM_MIRROR_LAST  7'h04
`define PMM_MIRROR_PCH   7'h0a
`define PMM_MIRROR_INT   7'h0b
`define PMM_GPR_DEPTH    256
`define PMM_GPR_AW       8
`endif

// file: inc/pmm_pkg.sv
// Purpose: Types for the program and data memory map
// Assumes: Constants header available
// Notes:   Types only
`include "pmm_consts.svh"
package pmm_pkg;
	typedef enum logic [1:0] {
		PMM_REG_SFR,
		PMM_REG_GPR,
		PMM_REG_NONE
	} pmm_region_t;

	typedef struct packed {
		logic                     valid;
		logic                     write;
		logic                     indirect;
		logic [`PMM_BANK_AW-1:0]  bank_addr;
		logic [7:0]               wdata;
	} pmm_data_req_t;

	typedef struct packed {
		pmm_region_t              region;
		logic [`PMM_DATA_AW-1:0]  sfr_addr;
		logic [`PMM_DATA_AW-1:0]  full_addr;
	} pmm_decode_t;
endpackage

// file: verilog/pmm_gpr_ram.sv
// Purpose: General purpose static RAM array
// Assumes: One write or read per cycle
// Notes:   Read data registered, one cycle latency
`timescale 1ns/100ps
`include "pmm_consts.svh"
module pmm_gpr_ram
	import pmm_pkg::*;
#(
	parameter int DEPTH = `PMM_GPR_DEPTH,
	parameter int AW    = `PMM_GPR_AW
) (
	// Clock
	input  wire logic          sys_clk_i,
	// Access
	input  wire logic          en_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [7:0]    wdata_i,
	output logic      [7:0]    rdata_o
);
	logic [7:0] mem [DEPTH];

	// No reset on the array: static RAM powers up unknown
	always_ff @(posedge sys_clk_i) begin
		if (en_i && we_i)
			mem[addr_i] <= wdata_i;
		if (en_i && !we_i)
			rdata_o <= mem[addr_i];
	end
endmodule

// file: verification/pmm_core_model.sv
// Purpose: Special register side of the core
// Assumes: Read data sampled in the request cycle
// Notes:   Unselected bus shows inverse of last value
`timescale 1ns/100ps
module pmm_core_model (
	input  wire logic       sys_clk_i,
	input  wire logic       sel_i,
	input  wire logic [8:0] addr_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] last;
	wire logic [7:0] val = addr_i[7:0] ^ 8'h5a;
	always_ff @(posedge sys_clk_i) if (sel_i) last <= val;
	assign rdata_o = sel_i ? val : ~last;
endmodule

// file: verification/pmm_memory_map_monitor.sv
// Purpose: Port assertions for the memory map
// Assumes: Bound to every map instance
// Notes:   Offset 0 left to the bench
`timescale 1ns/100ps
module pmm_memory_map_monitor
	import pmm_pkg::*;
(
	input wire logic sys_clk_i, rst_n_i, pc_advance_i, pc_load_i, int_take_i, data_rvalid_o, sfr_sel_o, gpr_hit_o,
	input wire logic bank_select_high_i, bank_select_low_i,
	input wire logic [12:0] pc_target_i, pc_o,
	input wire logic [11:0] prog_addr_o,
	input wire pmm_data_req_t data_req_i,
	input wire logic [8:0] sfr_addr_o,
	input wire logic [1:0] bank_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [6:0] off = data_req_i.bank_addr;
	wire logic dir = data_req_i.valid && !data_req_i.indirect;
	wire logic mir = off inside {[7'h01:7'h04], 7'h0a, 7'h0b};
	sequence s_read;
		data_req_i.valid && !data_req_i.write;
	endsequence
	a_reset_start: assert property ($rose(rst_n_i) |-> pc_o == 13'h0) else $error("pc not zero");
	a_int_vector: assert property (int_take_i |=> pc_o == 13'h4) else $error("bad vector");
	a_pc_load: assert property (pc_load_i && !int_take_i |=> pc_o == $past(pc_target_i)) else $error("bad load");
	a_pc_step: assert property (pc_advance_i && !pc_load_i && !int_take_i |=> pc_o == $past(pc_o) + 13'h1)
		else $error("bad step");
	a_fetch_wrap: assert property (prog_addr_o == pc_o[11:0]) else $error("bad fetch");
	a_bank_pick: assert property (bank_o == {bank_select_high_i, bank_select_low_i}) else $error("bad bank");
	a_read_answer: assert property (s_read |=> data_rvalid_o) else $error("no answer");
	a_sfr_low: assert property (dir && off inside {[7'h01:7'h1f]} |-> sfr_sel_o && !gpr_hit_o) else $error("not sfr");
	a_ram_high: assert property (dir && off > 7'h1f |-> gpr_hit_o && !sfr_sel_o) else $error("not ram");
	a_mirror_fold: assert property (dir && mir |-> sfr_addr_o == {2'b00, off}) else $error("not folded");
	a_direct_addr: assert property (dir && sfr_sel_o && !mir && off != 7'h0 |-> sfr_addr_o == {bank_o, off})
		else $error("bad address");
endmodule
bind pmm_memory_map pmm_memory_map_monitor pmm_memory_map_monitor_inst(.*);

// file: verification/tb.sv
// Purpose: Self-checking bench for the memory map
// Assumes: Inputs driven at the falling edge
// Notes:   Banks 0/2 and 1/3 share RAM bytes
`timescale 1ns/100ps
module tb;
	import pmm_pkg::*;
	logic sys_clk_i, rst_n_i, adv, ld, it, bh, bl, ib, sel, gh, rv, sw;
	logic [12:0] tgt, pc;
	logic [11:0] pa;
	logic [7:0] ptr, rd, srd, q, swd;
	logic [8:0] sa;
	logic [10:0] snap;
	logic [8:0] wsnap;
	logic [1:0] bk;
	pmm_data_req_t req;
	int n_mismatch = 0;
	int comparisons = 0;
	pmm_memory_map pmm_memory_map_inst(.sys_clk_i, .rst_n_i, .pc_advance_i(adv), .pc_load_i(ld), .pc_target_i(tgt),
		.int_take_i(it), .pc_o(pc), .prog_addr_o(pa), .bank_select_high_i(bh), .bank_select_low_i(bl),
		.indirect_bank_i(ib), .indirect_pointer_i(ptr), .data_req_i(req), .data_rdata_o(rd), .data_rvalid_o(rv),
		.sfr_sel_o(sel), .sfr_addr_o(sa), .sfr_write_o(sw), .sfr_wdata_o(swd), .sfr_rdata_i(srd),
		.bank_o(bk), .gpr_hit_o(gh));
	pmm_core_model pmm_core_model_inst(.sys_clk_i, .sel_i(sel), .addr_i(sa), .rdata_o(srd));
	task automatic chk(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, g, e);
		end
	endtask
	// Valid stays high so accesses run back to back
	task automatic acc(input logic w, i, input logic [6:0] o, input logic [7:0] d);
		req = {1'b1, w, i, o, d};
		#1 snap = {sel, gh, sa};
		wsnap = {sw, swd};
		@(negedge sys_clk_i);
		q = rd;
		chk(rv, !w);
	endtask
	task t_pc;
		chk(pc, 0);
		adv = 1;
		repeat (3) @(negedge sys_clk_i);
		chk(pc, 3);
		ld = 1;
		tgt = 13'h1fff;
		@(negedge sys_clk_i);
		chk({pc, pa}, {13'h1fff, 12'hfff});
		ld = 0;
		@(negedge sys_clk_i);
		chk(pc, 0);
		{ld, it} = 2'b11;
		@(negedge sys_clk_i);
		chk(pc, 4);
		{adv, ld, it} = 0;
	endtask
	task t_data;
		for (int b = 0; b < 4; b++) begin
			{bh, bl} = b[1:0];
			acc(1, 0, 7'h6f, {6'h04, b[1:0]});
			chk({bk, snap[9], wsnap[8]}, {b[1:0], 2'b10});
			acc(0, 0, 7'h6f, 0);
			chk(q, 8'h10 + b);
			acc(0, 0, 7'h05, 0);
			chk({snap, q}, {2'b10, b[1:0], 7'h05, {b[0], 7'h05} ^ 8'h5a});
			acc(1, 0, 7'h05, {6'h28, b[1:0]});
			chk({snap[10:9], wsnap}, {3'b101, 6'h28, b[1:0]});
			acc(0, 0, 7'h03, 0);
			chk(snap, {2'b10, 9'h003});
		end
		ptr = 8'hef;
		ib = 1;
		acc(0, 1, 7'h00, 0);
		chk(q, 8'h13);
		acc(0, 0, 7'h00, 0);
		chk(q, 8'h13);
		req = 0;
	endtask
	task end_sim;
		if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		sys_clk_i = 0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#5000 n_mismatch++;
		end_sim;
	end
	initial begin
		{rst_n_i, adv, ld, it, bh, bl, ib, tgt, ptr, req} = 0;
		repeat (16) @(negedge sys_clk_i);
		rst_n_i = 1;
		@(negedge sys_clk_i);
		t_pc;
		t_data;
		end_sim;
	end
endmodule
